// ==== oamd_decoder.v ====
// Purpose: sequence the operand bytes of one instruction and form its address
// Assumes: memory data stands while mem_rd is high and is taken at the edge ending it
// Notes: opcode-to-mode mapping is done upstream; this block only sequences
// Overview of operation
// - Inherent instructions are one byte; no further fetch.
// - Immediate: one byte after opcode is the operand value, no memory access.
// - Short direct: one address byte, range 00 to FF.
// - Long direct: two-byte address reaches the whole 64K space.
// - Indexed address is unsigned sum of X or Y and offset.
// - Indexed without offset fetches nothing; index alone is the address.
// - Short indexed: one offset byte, sum reaches 1FE with carry kept.
// - Long indexed: two-byte offset plus index reaches full 64K.
// - Indirect: byte after opcode is pointer address; pointer read before operand.
// - Short indirect: one-byte pointer, operand address 00 to FF.
// - Long indirect forms read a 16-bit pointer from a one-byte pointer address.
// - Indirect indexed adds X or Y to the fetched pointer.
// - Short indirect indexed: byte pointer plus index, reaching 1FE.
// - Load, compare, logic, arithmetic groups accept short and long forms.
// - Read-modify-write, bit, shift, swap, call, jump groups accept short only.
// - Relative mode adds a signed 8-bit offset to the program counter.
// - Direct relative: displacement byte follows the opcode.
// - Mask set raises interrupt mask to 3; mask clear lowers it to 0.
// - Indirect relative: byte after the opcode is a page-zero address; the displacement is read from there.
`timescale 1ns/1ps
`include "oamd_defs.vh"
module oamd_decoder (
	clk_sys,
	srst,
	start,
	mode,
	group,
	use_y,
	pc_in,
	x_val,
	y_val,
	mem_rdata,
	mem_rd,
	mem_addr,
	busy,
	done,
	illegal,
	eff_addr,
	operand,
	operand_valid,
	pc_load,
	pc_next,
	instr_len,
	imask
);
	input wire clk_sys;
	input wire srst;
	input wire start;
	input wire [3:0] mode;
	input wire [3:0] group;
	input wire use_y;
	input wire [15:0] pc_in;
	input wire [7:0] x_val;
	input wire [7:0] y_val;
	input wire [7:0] mem_rdata;
	output reg mem_rd;
	output reg [15:0] mem_addr;
	output reg busy;
	output reg done;
	output reg illegal;
	output reg [15:0] eff_addr;
	output reg [7:0] operand;
	output reg operand_valid;
	output reg pc_load;
	output reg [15:0] pc_next;
	output reg [2:0] instr_len;
	output reg [1:0] imask;

	localparam ST_IDLE = 3'h0;
	localparam ST_REQ = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_FINISH = 3'h3;

	// Fetch kinds for each memory read
	localparam FK_BYTE0 = 3'h0;
	localparam FK_HI = 3'h1;
	localparam FK_LO = 3'h2;
	localparam FK_PTR_HI = 3'h3;
	localparam FK_PTR_LO = 3'h4;
	localparam FK_PTR_B = 3'h5;
	localparam FK_DISP = 3'h6;

	reg [2:0] state_reg;
	reg [2:0] fk_reg;
	reg [3:0] mode_reg;
	reg [3:0] group_reg;
	reg [7:0] index_reg;
	reg [15:0] pc_reg;
	reg [7:0] byte_reg;
	reg [15:0] word_reg;
	reg [7:0] ptr_reg;
	reg [2:0] state_next;
	reg [2:0] fk_next;

	wire legal_w;
	wire [1:0] extra_w;
	wire [15:0] ea_w;
	wire [15:0] target_w;

	oamd_mode_check u_check (
		.mode(mode),
		.group(group),
		.legal(legal_w),
		.extra_bytes(extra_w)
	);

	oamd_addr_calc u_calc (
		.mode(mode_reg),
		.index_val(index_reg),
		.word_val(word_reg),
		.byte_val(byte_reg),
		.pc_val(pc_reg),
		.eff_addr(ea_w),
		.pc_target(target_w)
	);

	function needs_ptr_word;
		input [3:0] m;
		begin
			needs_ptr_word = (m == `OAMD_MODE_IND_L) || (m == `OAMD_MODE_IIX_L);
		end
	endfunction

	// Next fetch after the current read completes; ST_FINISH when no more
	always @* begin
		state_next = ST_FINISH;
		fk_next = fk_reg;
		case (fk_reg)
			FK_BYTE0: begin
				if (mode_reg == `OAMD_MODE_DIR_L || mode_reg == `OAMD_MODE_IDX_L) begin
					state_next = ST_REQ;
					fk_next = FK_LO;
				end else if (needs_ptr_word(mode_reg)) begin
					state_next = ST_REQ;
					fk_next = FK_PTR_HI;
				end else if (mode_reg == `OAMD_MODE_IND_S || mode_reg == `OAMD_MODE_IIX_S) begin
					state_next = ST_REQ;
					fk_next = FK_PTR_B;
				end else if (mode_reg == `OAMD_MODE_REL_I) begin
					state_next = ST_REQ;
					fk_next = FK_DISP;
				end
			end
			FK_PTR_HI: begin
				state_next = ST_REQ;
				fk_next = FK_PTR_LO;
			end
			default: state_next = ST_FINISH;
		endcase
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= ST_IDLE;
			fk_reg <= FK_BYTE0;
			mode_reg <= `OAMD_MODE_INH;
			group_reg <= `OAMD_GRP_OTHER;
			index_reg <= 8'h00;
			pc_reg <= 16'h0000;
			byte_reg <= 8'h00;
			word_reg <= 16'h0000;
			ptr_reg <= 8'h00;
			mem_rd <= 1'b0;
			mem_addr <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			illegal <= 1'b0;
			eff_addr <= 16'h0000;
			operand <= 8'h00;
			operand_valid <= 1'b0;
			pc_load <= 1'b0;
			pc_next <= 16'h0000;
			instr_len <= 3'h0;
			imask <= `OAMD_IMASK_RST;
		end else begin
			mem_rd <= 1'b0;
			done <= 1'b0;
			pc_load <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						mode_reg <= mode;
						group_reg <= group;
						index_reg <= use_y ? y_val : x_val;
						illegal <= !legal_w;
						operand_valid <= 1'b0;
						busy <= 1'b1;
						// pc_in points at the opcode
						instr_len <= {1'b0, extra_w} + 3'h1;
						pc_reg <= pc_in + 16'h0001;
						fk_reg <= FK_BYTE0;
						if (!legal_w || extra_w == 2'h0) begin
							state_reg <= ST_FINISH;
						end else begin
							state_reg <= ST_REQ;
						end
					end
				end
				ST_REQ: begin
					mem_rd <= 1'b1;
					state_reg <= ST_WAIT;
					case (fk_reg)
						FK_BYTE0: mem_addr <= pc_reg;
						// pc_reg already points past the opcode, so the low byte is one further
						FK_LO: mem_addr <= pc_reg + 16'h0001;
						FK_PTR_HI, FK_PTR_B, FK_DISP: mem_addr <= {8'h00, byte_reg};
						default: mem_addr <= {8'h00, ptr_reg + 8'h01}; // Pointer wraps in page zero
					endcase
				end
				ST_WAIT: begin
					case (fk_reg)
						FK_BYTE0: begin
							byte_reg <= mem_rdata;
							ptr_reg <= mem_rdata;
							word_reg <= {mem_rdata, 8'h00};
						end
						FK_LO: word_reg <= {word_reg[15:8], mem_rdata};
						FK_PTR_HI: word_reg <= {mem_rdata, 8'h00};
						FK_PTR_LO: word_reg <= {word_reg[15:8], mem_rdata};
						default: byte_reg <= mem_rdata; // Byte pointer or displacement
					endcase
					fk_reg <= fk_next;
					state_reg <= state_next;
				end
				ST_FINISH: begin
					busy <= 1'b0;
					done <= 1'b1;
					state_reg <= ST_IDLE;
					if (!illegal) begin
						if (mode_reg == `OAMD_MODE_IMM) begin
							operand <= byte_reg;
							operand_valid <= 1'b1;
						end
						eff_addr <= ea_w;
						if (mode_reg == `OAMD_MODE_REL_D || mode_reg == `OAMD_MODE_REL_I) begin
							pc_load <= 1'b1;
							pc_next <= target_w + {13'h0000, instr_len} - 16'h0001;
						end
						if (group_reg == `OAMD_GRP_MASK_SET) begin
							imask <= `OAMD_IMASK_SET;
						end else if (group_reg == `OAMD_GRP_MASK_CLR) begin
							imask <= `OAMD_IMASK_CLR;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
endmodule // oamd_decoder

// ==== oamd_defs.vh ====
// Purpose: constants for the operand address mode decoder
// Assumes: 8-bit data, 16-bit addresses, big-endian word fetch
// Notes: mode and group codes are shared by all decoder files
`ifndef OAMD_DEFS_VH
`define OAMD_DEFS_VH
`define OAMD_MODE_INH 4'h0
`define OAMD_MODE_IMM 4'h1
`define OAMD_MODE_DIR_S 4'h2
`define OAMD_MODE_DIR_L 4'h3
`define OAMD_MODE_IDX_0 4'h4
`define OAMD_MODE_IDX_S 4'h5
`define OAMD_MODE_IDX_L 4'h6
`define OAMD_MODE_IND_S 4'h7
`define OAMD_MODE_IND_L 4'h8
`define OAMD_MODE_IIX_S 4'h9
`define OAMD_MODE_IIX_L 4'hA
`define OAMD_MODE_REL_D 4'hB
`define OAMD_MODE_REL_I 4'hC
`define OAMD_GRP_LONG_OK 4'h0
`define OAMD_GRP_SHORT_ONLY 4'h1
`define OAMD_GRP_RELATIVE 4'h2
`define OAMD_GRP_MASK_SET 4'h3
`define OAMD_GRP_MASK_CLR 4'h4
`define OAMD_GRP_OTHER 4'h5
`define OAMD_IMASK_SET 2'h3
`define OAMD_IMASK_CLR 2'h0
`define OAMD_IMASK_RST 2'h3
`endif

// ==== oamd_mode_check.v ====
// Purpose: legality and operand-byte count of a mode for an instruction group
// Assumes: combinational, group and mode from the opcode decoder
// Notes: illegal combinations are reported, never executed
`timescale 1ns/1ps
`include "oamd_defs.vh"
module oamd_mode_check (
	mode,
	group,
	legal,
	extra_bytes
);
	input wire [3:0] mode;
	input wire [3:0] group;
	output reg legal;
	output reg [1:0] extra_bytes;

	wire is_long;
	assign is_long = (mode == `OAMD_MODE_DIR_L) || (mode == `OAMD_MODE_IDX_L) ||
		(mode == `OAMD_MODE_IND_L) || (mode == `OAMD_MODE_IIX_L);

	always @* begin
		case (mode)
			`OAMD_MODE_INH: extra_bytes = 2'h0;
			`OAMD_MODE_IDX_0: extra_bytes = 2'h0;
			`OAMD_MODE_IMM, `OAMD_MODE_DIR_S, `OAMD_MODE_IDX_S: extra_bytes = 2'h1;
			`OAMD_MODE_DIR_L, `OAMD_MODE_IDX_L: extra_bytes = 2'h2;
			default: extra_bytes = 2'h1;
		endcase
		case (group)
			`OAMD_GRP_LONG_OK: legal = (mode != `OAMD_MODE_REL_D) && (mode != `OAMD_MODE_REL_I);
			`OAMD_GRP_SHORT_ONLY: legal = !is_long && (mode != `OAMD_MODE_IMM) &&
				(mode != `OAMD_MODE_REL_D) && (mode != `OAMD_MODE_REL_I);
			`OAMD_GRP_RELATIVE: legal = (mode == `OAMD_MODE_REL_D) || (mode == `OAMD_MODE_REL_I);
			default: legal = (mode == `OAMD_MODE_INH);
		endcase
	end
endmodule // oamd_mode_check

// ==== oamd_addr_calc.v ====
// Purpose: effective address and relative target arithmetic
// Assumes: combinational, operands already gathered
// Notes: indexed sums keep the carry; relative offsets are sign-extended
`timescale 1ns/1ps
`include "oamd_defs.vh"
module oamd_addr_calc (
	mode,
	index_val,
	word_val,
	byte_val,
	pc_val,
	eff_addr,
	pc_target
);
	input wire [3:0] mode;
	input wire [7:0] index_val;
	input wire [15:0] word_val;
	input wire [7:0] byte_val;
	input wire [15:0] pc_val;
	output reg [15:0] eff_addr;
	output wire [15:0] pc_target;

	function [15:0] add_index;
		input [15:0] base;
		input [7:0] idx;
		begin
			add_index = base + {8'h00, idx};
		end
	endfunction

	// Wraps at 64K, as the program counter does
	assign pc_target = pc_val + {{8{byte_val[7]}}, byte_val};

	always @* begin
		case (mode)
			`OAMD_MODE_DIR_S, `OAMD_MODE_IND_S: eff_addr = {8'h00, byte_val};
			`OAMD_MODE_DIR_L, `OAMD_MODE_IND_L: eff_addr = word_val;
			`OAMD_MODE_IDX_0: eff_addr = {8'h00, index_val};
			`OAMD_MODE_IDX_S, `OAMD_MODE_IIX_S: eff_addr = add_index({8'h00, byte_val}, index_val);
			`OAMD_MODE_IDX_L, `OAMD_MODE_IIX_L: eff_addr = add_index(word_val, index_val);
			default: eff_addr = 16'h0000;
		endcase
	end
endmodule // oamd_addr_calc

// ==== oamd_mem_model.sv ====
// Purpose: program and data memory answering the decoder's byte reads
// Assumes: read data stands while mem_rd is high, loaded by the bench
// Notes: outside a read the last byte shows inverted, so stale bytes never match
`timescale 1ns/1ps
module oamd_mem_model (
	input wire logic clk_sys,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q = 8'h00;
	// The decoder takes the byte at the edge that ends its mem_rd cycle
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
	always @(posedge clk_sys) begin
		if (mem_rd)
			last_q <= mem[mem_addr];
	end
endmodule // oamd_mem_model

// ==== oamd_props.sv ====
// Purpose: timing and address checks on the operand decoder ports
// Assumes: one clock, synchronous reset
// Notes: a start is taken whenever busy is low, the done cycle included
`timescale 1ns/1ps
`include "oamd_defs.vh"
module oamd_props (
	input logic clk_sys,
	input logic srst,
	input logic start,
	input logic busy,
	input logic done,
	input logic [3:0] mode,
	input logic [3:0] group,
	input logic use_y,
	input logic [15:0] pc_in,
	input logic [7:0] x_val,
	input logic [7:0] y_val,
	input logic mem_rd,
	input logic [15:0] mem_addr,
	input logic illegal,
	input logic [15:0] eff_addr,
	input logic operand_valid,
	input logic pc_load,
	input logic [2:0] instr_len,
	input logic [1:0] imask
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire tk = start && !busy;
	wire lok = group == `OAMD_GRP_LONG_OK;
	property p_inh;
		tk && mode == `OAMD_MODE_INH |=> !mem_rd ##1 done && !mem_rd;
	endproperty
	a_inh: assert property (p_inh) else $error("inherent op fetched or ran late");
	property p_imm;
		tk && mode == `OAMD_MODE_IMM && lok |=> instr_len == 3'h2 ##1 mem_rd && mem_addr == $past(pc_in, 2) + 16'h1
			##2 done && operand_valid;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate sequence wrong");
	property p_dirl;
		tk && mode == `OAMD_MODE_DIR_L && lok |-> ##2 mem_rd && mem_addr == $past(pc_in, 2) + 16'h1
			##2 mem_rd && mem_addr == $past(pc_in, 4) + 16'h2;
	endproperty
	a_dirl: assert property (p_dirl) else $error("long address bytes out of order");
	property p_long_ok;
		tk && mode == `OAMD_MODE_DIR_L && lok |=> busy && !illegal ##5 done;
	endproperty
	a_long_ok: assert property (p_long_ok) else $error("long form refused for load group");
	property p_short_only;
		tk && group == `OAMD_GRP_SHORT_ONLY && (mode == `OAMD_MODE_DIR_L || mode == `OAMD_MODE_IDX_L) |=> illegal;
	endproperty
	a_short_only: assert property (p_short_only) else $error("long form accepted");
	property p_idx0;
		tk && mode == `OAMD_MODE_IDX_0 && lok |-> ##2 done && !mem_rd
			&& eff_addr == {8'h00, $past(use_y, 2) ? $past(y_val, 2) : $past(x_val, 2)};
	endproperty
	a_idx0: assert property (p_idx0) else $error("no offset index address wrong");
	property p_rel;
		tk && mode == `OAMD_MODE_REL_D && group == `OAMD_GRP_RELATIVE |-> ##4 pc_load && done;
	endproperty
	a_rel: assert property (p_rel) else $error("relative jump not loaded");
	property p_pcl;
		pc_load |-> done && !illegal;
	endproperty
	a_pcl: assert property (p_pcl) else $error("stray program counter load");
	property p_mset;
		tk && mode == `OAMD_MODE_INH && group == `OAMD_GRP_MASK_SET |-> ##2 imask == 2'h3;
	endproperty
	a_mset: assert property (p_mset) else $error("mask not raised");
	property p_mclr;
		tk && mode == `OAMD_MODE_INH && group == `OAMD_GRP_MASK_CLR |-> ##2 imask == 2'h0;
	endproperty
	a_mclr: assert property (p_mclr) else $error("mask not lowered");
	c_ill: cover property (done && illegal);
	c_rel: cover property (pc_load);
	c_refuse: cover property (start && busy);
endmodule // oamd_props
bind oamd_decoder oamd_props oamd_props_i (.clk_sys(clk_sys), .srst(srst), .start(start), .busy(busy),
	.done(done), .mode(mode), .group(group), .use_y(use_y), .pc_in(pc_in), .x_val(x_val), .y_val(y_val),
	.mem_rd(mem_rd), .mem_addr(mem_addr), .illegal(illegal), .eff_addr(eff_addr),
	.operand_valid(operand_valid), .pc_load(pc_load), .instr_len(instr_len), .imask(imask));

// ==== oamd_decoder_tb.sv ====
// Purpose: self-checking bench for the operand decoder
// Assumes: opcode at 1000, X=FF, Y=07, memory preloaded
// Notes: every row after the first starts in the cycle of the previous done
`timescale 1ns/1ps
`include "oamd_defs.vh"
module oamd_decoder_tb;
	typedef struct {logic [3:0] m, g; logic y; logic [2:0] len; logic ill; int cyc, sel; logic [15:0] v;} oamd_row_t;
	logic clk_sys, srst, start, use_y, mem_rd, busy, done, illegal, operand_valid, pc_load;
	logic [3:0] mode, group;
	logic [15:0] pc_in, mem_addr, eff_addr, pc_next;
	logic [7:0] x_val, y_val, mem_rdata, operand;
	logic [2:0] instr_len;
	logic [1:0] imask;
	int err_total = 0, total_checks = 0, n, i;
	oamd_row_t rows [17] = '{
		'{`OAMD_MODE_INH, `OAMD_GRP_OTHER, 0, 1, 0, 2, 0, 0},
		'{`OAMD_MODE_IMM, `OAMD_GRP_LONG_OK, 0, 2, 0, 4, 2, 16'h0080},
		'{`OAMD_MODE_DIR_S, `OAMD_GRP_LONG_OK, 0, 2, 0, 4, 1, 16'h0080},
		'{`OAMD_MODE_DIR_L, `OAMD_GRP_LONG_OK, 0, 3, 0, 6, 1, 16'h8034},
		'{`OAMD_MODE_IDX_0, `OAMD_GRP_LONG_OK, 0, 1, 0, 2, 1, 16'h00FF},
		'{`OAMD_MODE_IDX_S, `OAMD_GRP_LONG_OK, 0, 2, 0, 4, 1, 16'h017F},
		'{`OAMD_MODE_IDX_L, `OAMD_GRP_LONG_OK, 1, 3, 0, 6, 1, 16'h803B},
		'{`OAMD_MODE_IND_S, `OAMD_GRP_LONG_OK, 0, 2, 0, 6, 1, 16'h00F0},
		'{`OAMD_MODE_IND_L, `OAMD_GRP_LONG_OK, 0, 2, 0, 8, 1, 16'hF012},
		'{`OAMD_MODE_IIX_S, `OAMD_GRP_LONG_OK, 0, 2, 0, 6, 1, 16'h01EF},
		'{`OAMD_MODE_IIX_L, `OAMD_GRP_LONG_OK, 1, 2, 0, 8, 1, 16'hF019},
		'{`OAMD_MODE_REL_D, `OAMD_GRP_RELATIVE, 0, 2, 0, 4, 3, 16'h0F82},
		'{`OAMD_MODE_REL_I, `OAMD_GRP_RELATIVE, 0, 2, 0, 6, 3, 16'h0FF2},
		'{`OAMD_MODE_DIR_L, `OAMD_GRP_SHORT_ONLY, 0, 0, 1, 2, 0, 0},
		'{`OAMD_MODE_DIR_S, `OAMD_GRP_SHORT_ONLY, 0, 2, 0, 4, 1, 16'h0080},
		'{`OAMD_MODE_INH, `OAMD_GRP_MASK_CLR, 0, 1, 0, 2, 4, 0},
		'{`OAMD_MODE_INH, `OAMD_GRP_MASK_SET, 0, 1, 0, 2, 4, 3}};
	oamd_decoder oamd_decoder_i (.clk_sys(clk_sys), .srst(srst), .start(start), .mode(mode), .group(group),
		.use_y(use_y), .pc_in(pc_in), .x_val(x_val), .y_val(y_val), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .busy(busy), .done(done), .illegal(illegal), .eff_addr(eff_addr),
		.operand(operand), .operand_valid(operand_valid), .pc_load(pc_load), .pc_next(pc_next),
		.instr_len(instr_len), .imask(imask));
	oamd_mem_model oamd_mem_model_i (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
	task chk(input string nm, input logic [15:0] e, s);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A held start is refused while busy, so counting resumes one cycle later
	task run(input oamd_row_t r, input bit hold);
		mode = r.m;
		group = r.g;
		use_y = r.y;
		start = 1'b1;
		@(negedge clk_sys);
		if (hold) begin
			mode = `OAMD_MODE_INH;
			@(negedge clk_sys);
		end
		start = 1'b0;
		// The count includes the cycle that carries start
		n = 1;
		while (n < 20 && done !== 1'b1) begin
			@(posedge clk_sys);
			#1 n++;
		end
		if (n == 20) begin
			err_total++;
			give_verdict;
		end
		@(negedge clk_sys);
	endtask
	task reset_chk(input int k);
		srst = 1'b1;
		repeat (k) @(negedge clk_sys);
		srst = 1'b0;
		chk("imask", 16'h3, imask);
		chk("busy", 0, busy);
		chk("eff_addr", 0, eff_addr);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		{start, mode, group, use_y} = 0;
		pc_in = 16'h1000;
		x_val = 8'hFF;
		y_val = 8'h07;
		oamd_mem_model_i.mem[16'h1001] = 8'h80;
		oamd_mem_model_i.mem[16'h1002] = 8'h34;
		oamd_mem_model_i.mem[16'h0080] = 8'hF0;
		oamd_mem_model_i.mem[16'h0081] = 8'h12;
		reset_chk(16);
		for (i = 0; i < 17; i++) begin
			run(rows[i], 0);
			chk("cycles", rows[i].cyc, n);
			chk("illegal", rows[i].ill, illegal);
			if (!rows[i].ill) chk("instr_len", rows[i].len, instr_len);
			if (rows[i].sel == 1) chk("eff_addr", rows[i].v, eff_addr);
			if (rows[i].sel == 2) chk("operand", rows[i].v, operand);
			if (rows[i].sel == 3) chk("pc_next", rows[i].v, pc_next);
			if (rows[i].sel == 4) chk("imask", rows[i].v, imask);
		end
		run(rows[3], 1);
		chk("held cycles", 5, n);
		chk("held eff_addr", 16'h8034, eff_addr);
		run(rows[15], 0);
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		reset_chk(1);
		run(rows[3], 0);
		chk("eff_addr", 16'h8034, eff_addr);
		give_verdict;
	end
endmodule // oamd_decoder_tb
